// *** src/adc_readout_pkg.sv ***
// Constants shared by the serial readout and conversion control
// Notes on behaviour
// RL1: Valid chip select fall clears counters, then enables data output and shift clock.
// RL2: Valid chip select rise stops the block accepting shift clock edges.
// RL3: Data output is released while deselected and driven while selected.
// RL4: First bit driven on selection is the MSB of the previous result.
// RL5: Each later shift clock fall presents the next bit; LSB on ninth.
// RL6: Tenth shift clock fall drives output low and holds it low.
// RL7: Sampling runs from the third to the tenth shift clock falling edge.
// RL8: Tenth fall hands conversion to the controller, independent of shift clock.
// RL9: Host supplies ten to sixteen shift clocks per selected transfer.
// RL10: Host waits one conversion period after the tenth fall before restarting.
// RL11: Eleventh rise must follow tenth fall in time, else sync lost.
// RL12: Chip select level counts only after holding the minimum period.
// RL13: Each finished result is latched and shifted out unchanged next transfer.
package adc_readout_pkg;

   localparam int unsigned CLK_PERIOD_NS   = 100;
   localparam int unsigned CS_HOLD_PS      = 1425000;
   localparam int unsigned SYNC_TIMEOUT_PS = 9500000;
   localparam int unsigned CONV_TIME_NS    = 21000;

   // Least time rounds up, longest time rounds down
   localparam int unsigned CS_HOLD_CYC  = (CS_HOLD_PS + CLK_PERIOD_NS * 1000 - 1)
                                          / (CLK_PERIOD_NS * 1000);
   localparam int unsigned SYNC_TO_CYC  = SYNC_TIMEOUT_PS / (CLK_PERIOD_NS * 1000);
   localparam int unsigned CONV_CYC     = CONV_TIME_NS / CLK_PERIOD_NS;

   localparam int unsigned RES_BITS     = 10;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam int unsigned STEP_CYC     = CONV_CYC / RES_BITS;

   localparam logic [4:0] EDGE_SAMPLE_START = 5'h03;
   localparam logic [4:0] EDGE_LAST_BIT     = 5'h09;
   localparam logic [4:0] EDGE_HANDOFF      = 5'h0A;
   localparam logic [4:0] EDGE_MAX          = 5'h10;

   localparam logic [9:0] RESULT_RESET      = 10'h000;

   typedef enum logic [2:0] {
      CONV_IDLE = 3'b001,
      CONV_RUN  = 3'b010,
      CONV_PUSH = 3'b100
   } conv_state_t;

endpackage

// *** src/adc_serial_readout_control.sv ***
// Serial readout, sampling window and conversion sequencing of the converter
`timescale 1ns/10ps
`default_nettype none
module adc_serial_readout_control
   import adc_readout_pkg::*;
#(
   parameter int unsigned RES_W      = RES_BITS,
   parameter int unsigned DEPTH      = FIFO_DEPTH,
   parameter int unsigned HOLD_CYC   = CS_HOLD_CYC,
   parameter int unsigned TIMEOUT    = SYNC_TO_CYC,
   parameter int unsigned BIT_CYC    = STEP_CYC
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // Serial pins from the host
   input  wire logic             i_cs_n,
   input  wire logic             i_io_clk,
   // Three-state serial result pin
   output logic                  o_dout,
   output logic                  o_dout_oe,
   // Analog front end control
   input  wire logic             i_cmp,
   output logic                  o_sample,
   output logic [RES_W-1:0]      o_dac_code,
   // Status
   output logic                  o_conv_busy,
   output logic                  o_selected,
   output logic                  o_sync_lost
);
   localparam int unsigned HW = $clog2(HOLD_CYC + 1);
   localparam int unsigned TW = $clog2(TIMEOUT + 1);
   localparam int unsigned SW = $clog2(BIT_CYC + 1);
   localparam int unsigned BW = $clog2(RES_W + 1);

   // Pin synchronisers
   logic cs_s1_r;
   logic cs_s2_r;
   logic clk_s1_r;
   logic clk_s2_r;
   logic clk_s3_r;
   logic cmp_s1_r;
   logic cmp_s2_r;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         clk_s1_r <= 1'b0;
         clk_s2_r <= 1'b0;
         clk_s3_r <= 1'b0;
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         cs_s1_r  <= i_cs_n;
         cs_s2_r  <= cs_s1_r;
         clk_s1_r <= i_io_clk;
         clk_s2_r <= clk_s1_r;
         clk_s3_r <= clk_s2_r;
         cmp_s1_r <= i_cmp;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   logic sclk_fall;
   logic sclk_rise;
   assign sclk_fall = clk_s3_r && !clk_s2_r;
   assign sclk_rise = !clk_s3_r && clk_s2_r;

   // Chip select qualification: a level is accepted only once it has held
   // for the minimum period, so short glitches never restart a transfer.
   logic          cs_valid_n_r;
   logic [HW-1:0] hold_cnt_r;
   logic          sel_start;
   logic          sel_end;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cs_valid_n_r <= 1'b1;
         hold_cnt_r   <= '0;
      end else if (cs_s2_r == cs_valid_n_r) begin
         hold_cnt_r <= '0;
      end else if (hold_cnt_r == HW'(HOLD_CYC - 1)) begin
         cs_valid_n_r <= cs_s2_r; // RL12
         hold_cnt_r   <= '0;
      end else begin
         hold_cnt_r <= hold_cnt_r + 1'b1;
      end
   end

   assign sel_start = cs_valid_n_r && (hold_cnt_r == HW'(HOLD_CYC - 1)) && !cs_s2_r;
   assign sel_end   = !cs_valid_n_r && (hold_cnt_r == HW'(HOLD_CYC - 1)) && cs_s2_r;

   // Selection state and shift clock enable
   logic selected_r;
   logic lost_r;
   logic edge_ok;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         selected_r <= 1'b0;
      end else if (sel_start) begin
         selected_r <= 1'b1; // RL1
      end else if (sel_end) begin
         selected_r <= 1'b0; // RL2
      end
   end

   assign edge_ok = selected_r && !lost_r;

   // Shift clock falling edge counter
   logic [4:0] edge_cnt_r;
   logic [4:0] edge_nxt;
   assign edge_nxt = edge_cnt_r + 5'h01;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         edge_cnt_r <= '0;
      end else if (sel_start) begin
         edge_cnt_r <= '0; // RL1
      end else if (edge_ok && sclk_fall && edge_cnt_r != EDGE_MAX) begin
         edge_cnt_r <= edge_nxt;
      end
   end

   // Eleventh rise watchdog; once lost, only a chip select toggle recovers
   logic [TW-1:0] to_cnt_r;
   logic          to_run_r;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         to_cnt_r <= '0;
         to_run_r <= 1'b0;
         lost_r   <= 1'b0;
      end else if (sel_start) begin
         to_cnt_r <= '0;
         to_run_r <= 1'b0;
         lost_r   <= 1'b0; // RL11
      end else if (edge_ok && sclk_fall && edge_nxt == EDGE_HANDOFF) begin
         to_cnt_r <= '0;
         to_run_r <= 1'b1;
      end else if (to_run_r) begin
         if (sclk_rise && selected_r) begin
            to_run_r <= 1'b0;
         end else if (!selected_r) begin
            to_run_r <= 1'b0;
         end else if (to_cnt_r == TW'(TIMEOUT)) begin
            to_run_r <= 1'b0;
            lost_r   <= 1'b1; // RL11
         end else begin
            to_cnt_r <= to_cnt_r + 1'b1;
         end
      end
   end

   // Result FIFO between the conversion controller and the output shifter
   logic             fifo_wr_valid;
   logic             fifo_wr_ready;
   logic [RES_W-1:0] fifo_wr_data;
   logic             fifo_rd_valid;
   logic             fifo_rd_ready;
   logic [RES_W-1:0] fifo_rd_data;

   result_fifo #(
      .WIDTH (RES_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_wr_valid (fifo_wr_valid),
      .o_wr_ready (fifo_wr_ready),
      .i_wr_data  (fifo_wr_data),
      .o_rd_valid (fifo_rd_valid),
      .i_rd_ready (fifo_rd_ready),
      .o_rd_data  (fifo_rd_data)
   );

   // A new result is taken only at selection; without one the last result repeats
   assign fifo_rd_ready = sel_start; // RL13

   // Output shift register
   logic [RES_W-1:0] last_res_r;
   logic [RES_W-1:0] shift_r;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         last_res_r <= RESULT_RESET;
      end else if (sel_start && fifo_rd_valid) begin
         last_res_r <= fifo_rd_data; // RL13
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         shift_r <= RESULT_RESET;
      end else if (sel_start) begin
         shift_r <= fifo_rd_valid ? fifo_rd_data : last_res_r; // RL4
      end else if (edge_ok && sclk_fall) begin
         if (edge_nxt <= EDGE_LAST_BIT) begin
            shift_r <= {shift_r[RES_W-2:0], 1'b0}; // RL5
         end else begin
            shift_r <= '0; // RL6
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_dout    <= 1'b0;
         o_dout_oe <= 1'b0;
      end else begin
         o_dout_oe <= selected_r; // RL3
         o_dout    <= selected_r ? shift_r[RES_W-1] : 1'b0; // RL4
      end
   end

   // Sampling window
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_sample <= 1'b0;
      end else if (sel_start) begin
         o_sample <= 1'b0;
      end else if (edge_ok && sclk_fall) begin
         if (edge_nxt == EDGE_SAMPLE_START) begin
            o_sample <= 1'b1; // RL7
         end else if (edge_nxt == EDGE_HANDOFF) begin
            o_sample <= 1'b0; // RL7
         end
      end
   end

   // Conversion controller: successive approximation, one bit per step,
   // running on the system clock alone once started.
   conv_state_t      conv_r;
   logic [BW-1:0]    bit_idx_r;
   logic [SW-1:0]    step_r;
   logic [RES_W-1:0] code_r;
   logic             start_conv;

   assign start_conv = edge_ok && sclk_fall && edge_nxt == EDGE_HANDOFF; // RL8

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         conv_r    <= CONV_IDLE;
         bit_idx_r <= '0;
         step_r    <= '0;
         code_r    <= '0;
      end else begin
         unique case (conv_r)
            CONV_IDLE: begin
               if (start_conv) begin
                  conv_r    <= CONV_RUN; // RL8
                  bit_idx_r <= BW'(RES_W - 1);
                  step_r    <= '0;
                  code_r    <= {1'b1, {(RES_W-1){1'b0}}};
               end
            end
            CONV_RUN: begin
               if (step_r == SW'(BIT_CYC - 1)) begin
                  step_r <= '0;
                  // Comparator high means the trial code overshoots
                  if (cmp_s2_r) begin
                     code_r[bit_idx_r] <= 1'b0;
                  end
                  if (bit_idx_r == '0) begin
                     conv_r <= CONV_PUSH;
                  end else begin
                     bit_idx_r                <= bit_idx_r - 1'b1;
                     code_r[bit_idx_r - 1'b1] <= 1'b1;
                  end
               end else begin
                  step_r <= step_r + 1'b1;
               end
            end
            CONV_PUSH: begin
               // Stalls here while the FIFO is full
               if (fifo_wr_ready) begin
                  conv_r <= CONV_IDLE;
               end
            end
         endcase
      end
   end

   assign fifo_wr_valid = (conv_r == CONV_PUSH);
   assign fifo_wr_data  = code_r;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_dac_code <= '0;
      end else begin
         o_dac_code <= code_r;
      end
   end

   assign o_conv_busy = (conv_r != CONV_IDLE);
   assign o_selected  = selected_r;
   assign o_sync_lost = lost_r;

endmodule
`default_nettype wire

// *** src/result_fifo.sv ***
// Parameterised flip-flop FIFO carrying finished conversion results
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   // Write side
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   input  wire logic [WIDTH-1:0] i_wr_data,
   // Read side
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready,
   output logic [WIDTH-1:0]      o_rd_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign o_wr_ready = (count_r != (AW+1)'(DEPTH));
   assign o_rd_valid = (count_r != '0);
   assign o_rd_data  = mem_r[rd_ptr_r];
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = i_rd_ready && o_rd_valid;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/adc_readout_chk.sv ***
// Port-level assertions for the converter serial readout control
`timescale 1ns/10ps
`default_nettype none
module adc_readout_chk #(
   parameter int unsigned RES_W = 10
) (
   // Clock, reset and serial pins
   input wire logic             i_clk, i_sys_rst, i_cs_n, i_io_clk, o_dout, o_dout_oe,
   // Analog front end
   input wire logic             i_cmp, o_sample,
   input wire logic [RES_W-1:0] o_dac_code,
   // Status
   input wire logic             o_conv_busy, o_selected, o_sync_lost
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_handoff;
      o_selected && $rose(o_conv_busy);
   endsequence
   sequence s_zero_tail;
      !o_dout [*8];
   endsequence

   // Eight cycles cover sync plus the shortened hold filter used by the bench
   property p_sel_oe;       $rose(o_selected) |-> ##[0:1] o_dout_oe; endproperty
   property p_cs_low_sel;   !i_cs_n [*8] |-> o_selected; endproperty
   property p_cs_high_off;  i_cs_n [*8] |-> !o_dout_oe && !o_selected; endproperty
   property p_oe_holds;     o_dout_oe && !i_cs_n |=> o_dout_oe; endproperty
   property p_idle_low;     !o_dout_oe |-> !o_dout; endproperty
   property p_handoff;      $fell(o_sample) && o_selected |-> ##[0:2] o_conv_busy; endproperty
   property p_tail_zero;    s_handoff |-> ##1 s_zero_tail; endproperty
   property p_window_excl;  o_sample |-> !o_conv_busy; endproperty
   property p_sync_clear;   $rose(o_selected) |-> ##[0:2] !o_sync_lost; endproperty

   a_sel_oe:      assert property (p_sel_oe) else $error("oe late after selection");
   a_cs_low_sel:  assert property (p_cs_low_sel) else $error("selection not taken");
   a_cs_high_off: assert property (p_cs_high_off) else $error("still on after deselect");
   a_oe_holds:    assert property (p_oe_holds) else $error("oe dropped while selected");
   a_idle_low:    assert property (p_idle_low) else $error("dout high while released");
   a_handoff:     assert property (p_handoff) else $error("no conversion after window");
   a_tail_zero:   assert property (p_tail_zero) else $error("dout not zero after tenth");
   a_window_excl: assert property (p_window_excl) else $error("sampling while converting");
   a_sync_clear:  assert property (p_sync_clear) else $error("sync loss kept on reselect");
endmodule
`default_nettype wire

// *** testbench/host_port_model.sv ***
// Host serial port and analog source at the far side of the converter
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
   // Clock
   input  wire logic       i_clk,
   // Device pins
   input  wire logic       i_dout,
   input  wire logic       i_sample,
   input  wire logic [9:0] i_dac_code,
   output logic            o_cs_n,
   output logic            o_io_clk,
   output logic            o_cmp
);
   logic [9:0] target;
   initial begin
      o_cs_n = 1'b1;
      o_io_clk = 1'b0;
      target = 10'h000;
   end
   // Comparator stand-in: high while the trial code is above the input
   assign o_cmp = i_dac_code > target;
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic set_level(input logic [9:0] level);
      target = level;
   endtask
   // Shift clocks while deselected; the block must ignore them
   task automatic idle_clocks(input int n);
      repeat (n) begin
         o_io_clk = 1'b1;
         tick(4);
         o_io_clk = 1'b0;
         tick(4);
      end
   endtask
   task automatic select(input int low);
      o_cs_n = 1'b0;
      tick(low);
   endtask
   // Long wait lets the conversion finish and the select level settle
   task automatic deselect();
      o_cs_n = 1'b1;
      tick(40);
   endtask
   // Bits are taken at the end of each high phase, long after dout settles
   task automatic xfer(input int n, input int pause, output logic [15:0] word,
                       output logic [15:0] smp);
      word = 16'h0000;
      smp = 16'h0000;
      for (int k = 0; k < n; k++) begin
         o_io_clk = 1'b1;
         tick(4);
         word[15-k] = i_dout;
         smp[k] = i_sample;
         o_io_clk = 1'b0;
         tick(k == 9 ? pause : 4);
      end
   endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the converter serial readout control
`timescale 1ns/10ps
`default_nettype none
module tb;
   import adc_readout_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        cs_n, io_clk, cmp, dout, dout_oe, sample, conv_busy, selected, sync_lost;
   logic [9:0]  dac_code;
   logic [9:0]  prev = 10'h000;
   logic [15:0] word, smp;
   logic        oe_seen = 1'b0;
   int          failures = 0;
   int          compares = 0;
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) if (dout_oe) oe_seen <= 1'b1;

   // A bit step must cover the code register plus the two comparator sync stages
   adc_serial_readout_control #(.HOLD_CYC(3), .TIMEOUT(10), .BIT_CYC(4))
      adc_serial_readout_control_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(cs_n),
      .i_io_clk(io_clk), .o_dout(dout), .o_dout_oe(dout_oe), .i_cmp(cmp), .o_sample(sample),
      .o_dac_code(dac_code), .o_conv_busy(conv_busy), .o_selected(selected),
      .o_sync_lost(sync_lost));
   host_port_model host_port_model_i (.i_clk(i_clk), .i_dout(dout), .i_sample(sample),
      .i_dac_code(dac_code), .o_cs_n(cs_n), .o_io_clk(io_clk), .o_cmp(cmp));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic t_first();
      check({10'h000, dout_oe, dout, sample, conv_busy, selected, sync_lost}, 16'h0000);
      host_port_model_i.select(10);
      check(16'(dout_oe), 16'h0001);
      host_port_model_i.xfer(10, 4, word, smp);
      check(word, 16'h0000);
      check(smp, 16'h03F8);
      host_port_model_i.tick(3);
      check(16'(conv_busy), 16'h0001);
      host_port_model_i.deselect();
      check({14'h0000, dout_oe, selected}, 16'h0000);
      $display("t_first done");
   endtask
   // Clocks sent while deselected must not shift anything
   task automatic t_results();
      logic [9:0] tab [4] = '{10'h2A5, 10'h15A, 10'h3FF, 10'h001};
      foreach (tab[i]) begin
         host_port_model_i.set_level(tab[i]);
         host_port_model_i.select(10);
         host_port_model_i.xfer(16, 4, word, smp);
         check(word, {prev, 6'h00});
         check(smp, 16'h03F8);
         host_port_model_i.deselect();
         host_port_model_i.idle_clocks(3);
         check({13'h0000, dout_oe, selected, sample}, 16'h0000);
         prev = tab[i];
      end
      $display("t_results done");
   endtask
   task automatic t_glitch();
      oe_seen = 1'b0;
      host_port_model_i.select(1);
      host_port_model_i.deselect();
      check({15'h0000, oe_seen}, 16'h0000);
      $display("t_glitch done");
   endtask
   task automatic t_sync();
      host_port_model_i.set_level(10'h0F0);
      host_port_model_i.select(10);
      host_port_model_i.xfer(16, 20, word, smp);
      check(word, {prev, 6'h00});
      check(16'(sync_lost), 16'h0001);
      host_port_model_i.deselect();
      host_port_model_i.select(10);
      check(16'(sync_lost), 16'h0000);
      host_port_model_i.xfer(10, 4, word, smp);
      check(word, {10'h0F0, 6'h00});
      host_port_model_i.deselect();
      $display("t_sync done");
   endtask

   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_sys_rst = 1'b0;
      host_port_model_i.tick(2);
      t_first();
      t_results();
      t_glitch();
      t_sync();
      conclude();
   end
   initial begin
      #3000000;
      failures++;
      conclude();
   end
endmodule
bind adc_serial_readout_control adc_readout_chk #(.RES_W(RES_W)) adc_readout_chk_i (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_io_clk(i_io_clk),
   .o_dout(o_dout), .o_dout_oe(o_dout_oe), .i_cmp(i_cmp), .o_sample(o_sample),
   .o_dac_code(o_dac_code), .o_conv_busy(o_conv_busy), .o_selected(o_selected),
   .o_sync_lost(o_sync_lost));
`default_nettype wire
